/* File: design/cwl_phase_gen.sv */
// CW local-oscillator phase generator: phase counter, cross-point phase selection,
// quadrature generation and per-channel weighting. Carrier clocks are sampled as
// ordinary synchronous inputs, so sys_clk_i must run well above the multiplied clock.
//
// Function
// - Takes a multiplied carrier clock (16x, 8x, 4x or 1x) and a carrier-rate clock.
// - Sixteen-times mode is the default until another multiplier is configured.
// - Sixteen-times mode derives sixteen evenly spaced oscillator phases from the input.
// - Outside 1x mode the carrier-rate clock only aligns the starting phase, so devices stay phase-matched.
// - A sixteen-by-eight cross-point routes one phase version to each channel mixer.
// - Each successive phase input delays the oscillator by 22.5 degrees.
// - Eight- and four-times modes produce in-phase and quadrature clocks ninety degrees apart.
// - Those modes weight the paths by cosine and sine of the chosen angle.
// - Harmonic suppression is offered only in sixteen- and eight-times modes.
// - In-phase mixer gets the cosine oscillator, quadrature mixer the sine oscillator.
`timescale 1ns/1ps

module cwl_phase_gen
  import cwl_pkg::*;
(
  input  wire logic                  sys_clk_i,     // System clock, 20 MHz.
  input  wire logic                  srst_i,        // Synchronous reset, active high.
  input  wire logic                  ce_i,          // Clock enable; low freezes all state.
  input  wire logic                  clk_nx_i,      // Multiplied carrier clock level.
  input  wire logic                  clk_1x_i,      // Carrier-rate clock level.
  input  wire logic                  cfg_load_i,    // Pulse: load mode and phase codes.
  input  cwl_mode_t                  mode_i,        // Multiplier mode to load.
  input  wire logic [NCH*PH_W-1:0]   code_i,        // Phase codes, channel c at [c*4 +: 4].
  input  wire logic                  hs_req_i,      // Harmonic suppression requested.
  output cwl_mode_t                  mode_o,        // Mode in force.
  output cwl_lo_t   [NCH-1:0]        lo_o,          // Per-channel mixer oscillators.
  output cwl_wgt_t  [NCH-1:0]        wgt_o,         // Per-channel cosine and sine weights.
  output logic                       hs_en_o        // Harmonic suppression active.
);

  // Sine-shaped square wave: high over the first half of the sixteen-step cycle.
  function automatic logic sq_sin(input logic [PH_W-1:0] ph);
    sq_sin = (ph < PH_HALF);
  endfunction

  // Cosine leads sine by a quarter period.
  function automatic logic sq_cos(input logic [PH_W-1:0] ph);
    sq_cos = sq_sin(PH_W'(ph + PH_QUARTER));
  endfunction

  // Cosine of code times 22.5 degrees, folded from the quarter-wave table.
  function automatic logic signed [WGT_W-1:0] cos_tab(input logic [PH_W-1:0] k);
    logic [1:0]                q;
    logic [1:0]                m;
    logic signed [WGT_W-1:0]   v;
    q = k[3:2];
    m = (q[0]) ? 2'(~k[1:0] + 2'h1) : k[1:0];
    unique case (m)
      2'h0:    v = COS_Q0;
      2'h1:    v = COS_Q1;
      2'h2:    v = COS_Q2;
      default: v = COS_Q3;
    endcase
    if (q[0] && (k[1:0] == 2'h0))
      v = WGT_ZERO;
    if (q == 2'h1 || q == 2'h2)
      v = -v;
    cos_tab = v;
  endfunction

  // Configuration state.
  cwl_mode_t                 mode_r, mode_nxt;
  logic [NCH*PH_W-1:0]       code_r, code_nxt;

  // Sequencing state.
  logic                      nx_d_r, nx_d_nxt;
  logic                      x1_d_r, x1_d_nxt;
  logic [PH_W-1:0]           cnt_r, cnt_nxt;

  // Output state.
  cwl_lo_t   [NCH-1:0]       lo_r, lo_nxt;
  cwl_wgt_t  [NCH-1:0]       wgt_r, wgt_nxt;
  logic                      hs_r, hs_nxt;

  logic                      nx_rise;
  logic                      x1_rise;
  logic [PH_W-1:0]           step;

  // Edge detection on the sampled carrier clocks.
  assign nx_rise = clk_nx_i & ~nx_d_r;
  assign x1_rise = clk_1x_i & ~x1_d_r;

  // Configuration: mode defaults to sixteen-times; codes load together with it.
  always_comb
  begin
    mode_nxt = mode_r;
    code_nxt = code_r;
    if (cfg_load_i)
    begin
      mode_nxt = mode_i;
      code_nxt = code_i;
    end
  end

  // Phase counter advance per mode; in 1x mode there is nothing to subdivide.
  always_comb
  begin
    unique case (mode_r)
      MODE_16X: step = STEP_16X;
      MODE_8X:  step = STEP_8X;
      MODE_4X:  step = STEP_4X;
      MODE_1X:  step = STEP_1X;
    endcase
  end

  // The carrier-rate edge wins over the multiplied edge, so an aligned pair lands on zero.
  always_comb
  begin
    nx_d_nxt = clk_nx_i;
    x1_d_nxt = clk_1x_i;
    cnt_nxt  = cnt_r;
    if (x1_rise)
      cnt_nxt = PH_ZERO;
    else if (nx_rise)
      cnt_nxt = PH_W'(cnt_r + step);
  end

  // Oscillator routing and weights. In 16x each channel taps its own delayed phase;
  // in 8x/4x all channels share one quadrature pair and carry the phase in weights.
  // In 1x the clocks are passed straight through, in-phase on the 1x pin and
  // quadrature on the multiplied pin, since no finer phase can be built here.
  always_comb
  begin
    logic [PH_W-1:0] ph;
    ph  = PH_ZERO;
    for (int c = 0; c < NCH; c++)
    begin
      ph = PH_W'(cnt_r - code_r[c*PH_W +: PH_W]);
      unique case (mode_r)
        MODE_16X:
        begin
          lo_nxt[c].in_phase_channel   = sq_cos(ph);
          lo_nxt[c].quadrature_channel = sq_sin(ph);
          wgt_nxt[c].cos_w = COS_Q0;
          wgt_nxt[c].sin_w = WGT_ZERO;
        end
        MODE_8X, MODE_4X:
        begin
          lo_nxt[c].in_phase_channel   = sq_cos(cnt_r);
          lo_nxt[c].quadrature_channel = sq_sin(cnt_r);
          wgt_nxt[c].cos_w = cos_tab(code_r[c*PH_W +: PH_W]);
          wgt_nxt[c].sin_w = cos_tab(4'(code_r[c*PH_W +: PH_W] - PH_QUARTER));
        end
        MODE_1X:
        begin
          lo_nxt[c].in_phase_channel   = clk_1x_i;
          lo_nxt[c].quadrature_channel = clk_nx_i;
          wgt_nxt[c].cos_w = cos_tab(code_r[c*PH_W +: PH_W]);
          wgt_nxt[c].sin_w = cos_tab(4'(code_r[c*PH_W +: PH_W] - PH_QUARTER));
        end
      endcase
    end
    hs_nxt = hs_req_i && (mode_r == MODE_16X || mode_r == MODE_8X);
  end

  // Registers. Reset leaves the default mode and all codes at phase zero.
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      mode_r <= MODE_16X;
      code_r <= '0;
      nx_d_r <= 1'b0;
      x1_d_r <= 1'b0;
      cnt_r  <= PH_ZERO;
      lo_r   <= '0;
      wgt_r  <= '0;
      hs_r   <= 1'b0;
    end
    else if (ce_i)
    begin
      mode_r <= mode_nxt;
      code_r <= code_nxt;
      nx_d_r <= nx_d_nxt;
      x1_d_r <= x1_d_nxt;
      cnt_r  <= cnt_nxt;
      lo_r   <= lo_nxt;
      wgt_r  <= wgt_nxt;
      hs_r   <= hs_nxt;
    end
  end

  assign mode_o  = mode_r;
  assign lo_o    = lo_r;
  assign wgt_o   = wgt_r;
  assign hs_en_o = hs_r;

  // Reset lands in sixteen-times mode.
  a_default_mode: assert property (@(posedge sys_clk_i) srst_i |=> mode_r == MODE_16X)
    else $error("mode after reset is not 16x");

  // A carrier-rate rising edge restarts the sequence at phase zero.
  a_restart_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ce_i && clk_1x_i && !x1_d_r |=> cnt_r == PH_ZERO)
    else $error("phase counter not restarted by 1x edge");

  // In 16x mode each multiplied edge advances exactly one of sixteen phases.
  a_step_sixteen: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ce_i && mode_r == MODE_16X && !cfg_load_i && nx_rise && !x1_rise
    |=> cnt_r == 4'($past(cnt_r) + STEP_16X))
    else $error("16x step wrong");

  // Loaded codes are held.
  a_code_load: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ce_i && cfg_load_i |=> code_r == $past(code_i))
    else $error("phase codes not loaded");

  // In 16x the channel oscillator follows the code-delayed phase.
  a_phase_delay: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ce_i && mode_r == MODE_16X
    |=> lo_r[0].quadrature_channel == ($past(cnt_r) - $past(code_r[PH_W-1:0]) < PH_HALF))
    else $error("channel 0 phase delay wrong");

  // Quadrature pair stays a quarter period apart in 8x/4x mode.
  a_quad_offset: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ce_i && (mode_r == MODE_8X || mode_r == MODE_4X)
    |=> lo_r[0].in_phase_channel == (4'($past(cnt_r) + PH_QUARTER) < PH_HALF))
    else $error("quadrature offset wrong");

  // Code zero gives full cosine and no sine weight in 4x mode.
  a_weight_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ce_i && mode_r == MODE_4X && code_r[PH_W-1:0] == 4'h0
    |=> wgt_r[0].cos_w == COS_Q0 && wgt_r[0].sin_w == WGT_ZERO)
    else $error("weights for code zero wrong");

  // Suppression never active in 4x or 1x.
  a_harm_mode: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ce_i && (mode_r == MODE_4X || mode_r == MODE_1X) |=> !hs_en_o)
    else $error("harmonic suppression in 4x or 1x");

  // Phase counter and mode hold while the clock enable is low.
  a_freeze_state: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !ce_i |=> $stable(cnt_r) && $stable(mode_r))
    else $error("state moved with clock enable low");

endmodule // cwl_phase_gen

/* File: design/cwl_pkg.sv */
// Shared types and constants for the CW local-oscillator phase generator.
// Assumes a single system clock domain; carrier clocks arrive as sampled levels.
package cwl_pkg;

  // Number of mixer channels and width of a channel's phase code.
  localparam int unsigned NCH     = 8;
  localparam int unsigned PH_W    = 4;
  localparam int unsigned WGT_W   = 8;

  // Phase sequence geometry: sixteen phases, half period and quarter period in phase steps.
  localparam logic [PH_W-1:0] PH_ZERO    = 4'h0;
  localparam logic [PH_W-1:0] PH_HALF    = 4'h8;
  localparam logic [PH_W-1:0] PH_QUARTER = 4'h4;

  // Phase counter advance per multiplied-clock edge in each mode.
  localparam logic [PH_W-1:0] STEP_16X = 4'h1;
  localparam logic [PH_W-1:0] STEP_8X  = 4'h2;
  localparam logic [PH_W-1:0] STEP_4X  = 4'h4;
  localparam logic [PH_W-1:0] STEP_1X  = 4'h0;

  // Quarter-wave cosine table, full scale 127, for angles 0, 22.5, 45 and 67.5 degrees.
  localparam logic signed [WGT_W-1:0] COS_Q0 = 8'h7F;
  localparam logic signed [WGT_W-1:0] COS_Q1 = 8'h75;
  localparam logic signed [WGT_W-1:0] COS_Q2 = 8'h5A;
  localparam logic signed [WGT_W-1:0] COS_Q3 = 8'h31;
  localparam logic signed [WGT_W-1:0] WGT_ZERO = 8'h00;

  // Carrier multiplier modes; sixteen-times is the reset default.
  typedef enum logic [1:0] {
    MODE_16X,
    MODE_8X,
    MODE_4X,
    MODE_1X
  } cwl_mode_t;

  // Oscillator pair for one channel's two mixers.
  typedef struct packed {
    logic in_phase_channel;
    logic quadrature_channel;
  } cwl_lo_t;

  // Cosine and sine weights for one channel's in-phase and quadrature paths.
  typedef struct packed {
    logic signed [WGT_W-1:0] cos_w;
    logic signed [WGT_W-1:0] sin_w;
  } cwl_wgt_t;

endpackage

/* File: tb/cwl_clk_src.sv */
// Model of the external source of the two CW carrier clocks.
// Assumes it is stepped by the same system clock that runs the block.
`timescale 1ns/1ps

module cwl_clk_src #(
  parameter int NX_HALF = 2  // Multiplied-clock half period, in system clocks.
) (
  input  wire logic sys_clk_i,  // System clock.
  input  wire logic run_i,      // High while the carrier clocks run.
  input  int        mult_i,     // Multiplied periods per carrier period.
  output logic      clk_nx_o,   // Multiplied carrier clock.
  output logic      clk_1x_o    // Carrier-rate clock.
);
  int t = 0;

  // Outside 1x mode both clocks start high at t = 0, so rising edges line up.
  // Outside a burst both stand still low, as a gated source would.
  always @(posedge sys_clk_i)
  begin
    if (!run_i)
    begin
      t <= 0;
      clk_nx_o <= 1'b0;
      clk_1x_o <= 1'b0;
    end
    else
    begin
      // In 1x mode the multiplied pin carries the quadrature clock, a quarter period late.
      clk_nx_o <= (((mult_i == 1) ? t + 2 * NX_HALF - NX_HALF / 2 : t) % (2 * NX_HALF)) < NX_HALF;
      clk_1x_o <= t < NX_HALF * mult_i;
      t <= (t + 1) % (2 * NX_HALF * mult_i);
    end
  end
endmodule // cwl_clk_src

/* File: tb/testbench.sv */
// Self-checking bench for the CW oscillator phase generator.
// Assumes the clock-source model drives both carrier clock inputs.
`timescale 1ns/1ps

module testbench;
  import cwl_pkg::*;
  logic             sys_clk = 1'b0;
  logic             srst = 1'b1;
  logic             cfg_load = 1'b0;
  cwl_mode_t        mode_i = MODE_16X;
  logic [31:0]      code_i = 32'h0000_0000;
  logic             hs_req = 1'b0;
  logic             ce = 1'b1;
  logic             clk_nx, clk_1x, hs_en, src_run = 1'b0, chk_en = 1'b0, p1, pn;
  int               src_mult = 16, n_fail = 0, n_checks = 0, cyc = 0;
  cwl_mode_t        mode_o;
  cwl_lo_t [NCH-1:0] lo_o, exp_r, exp_d;
  cwl_wgt_t [NCH-1:0] wgt_o;
  logic [3:0]       cnt;

  always #25 sys_clk = ~sys_clk;

  cwl_clk_src i_src (.sys_clk_i(sys_clk), .run_i(src_run), .mult_i(src_mult),
    .clk_nx_o(clk_nx), .clk_1x_o(clk_1x));

  cwl_phase_gen i_dut (.sys_clk_i(sys_clk), .srst_i(srst), .ce_i(ce), .clk_nx_i(clk_nx),
    .clk_1x_i(clk_1x), .cfg_load_i(cfg_load), .mode_i(mode_i), .code_i(code_i),
    .hs_req_i(hs_req), .mode_o(mode_o), .lo_o(lo_o), .wgt_o(wgt_o), .hs_en_o(hs_en));

  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic cwl_lo_t lo_of(input logic [3:0] p);
    return cwl_lo_t'({(p + 4'h4) < 4'h8, p < 4'h8});
  endfunction

  function automatic logic signed [7:0] cosw(input logic [3:0] k);
    logic signed [7:0] m;
    logic [3:0]        s;
    case (k[2:0])
      3'd0: m = COS_Q0;
      3'd1, 3'd7: m = COS_Q1;
      3'd2, 3'd6: m = COS_Q2;
      3'd3, 3'd5: m = COS_Q3;
      default: m = WGT_ZERO;
    endcase
    s = k + 4'h4;
    return s[3] ? -m : m;
  endfunction

  // Reference phase counter; it follows every carrier edge from reset on.
  always @(posedge sys_clk)
  begin
    if (srst) cnt = 4'h0;
    else if (clk_1x && !p1) cnt = 4'h0;
    else if (clk_nx && !pn) cnt = cnt + ((mode_i == MODE_16X) ? STEP_16X :
      (mode_i == MODE_8X) ? STEP_8X : STEP_4X);
    p1 = clk_1x;
    pn = clk_nx;
    for (int c = 0; c < NCH; c++)
      exp_r[c] <= lo_of((mode_i == MODE_16X) ? cnt - code_i[c*4 +: 4] : cnt);
    // In 1x the pins pass straight through one edge late, with no counter stage.
    exp_d <= (mode_i == MODE_1X) ? {NCH{clk_1x, clk_nx}} : exp_r;
  end

  // Oscillator outputs are compared half a cycle after each edge.
  always @(negedge sys_clk)
    if (chk_en) chk("lo_o", exp_d, lo_o);

  task automatic load(input cwl_mode_t m, input logic [31:0] cd, input logic hs);
    @(posedge sys_clk);
    mode_i <= m;
    code_i <= cd;
    hs_req <= hs;
    cfg_load <= 1'b1;
    @(posedge sys_clk);
    cfg_load <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("mode_o", m, mode_o);
    chk("hs_en_o", hs && (m == MODE_16X || m == MODE_8X), hs_en);
  endtask

  task automatic burst(input int mult, input int n);
    @(posedge sys_clk);
    src_mult <= mult;
    src_run <= 1'b1;
    chk_en <= 1'b1;
    repeat (n) @(posedge sys_clk);
    src_run <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk_en <= 1'b0;
  endtask

  task automatic t_defaults;
    chk("mode_o", MODE_16X, mode_o);
    chk("lo_o", 0, lo_o);
    chk("wgt_o", 0, wgt_o);
    chk("hs_en_o", 0, hs_en);
  endtask

  // Sixteen phases, then a carrier period shorter than sixteen steps.
  task automatic t_sixteen;
    load(MODE_16X, 32'hFDB9_7531, 1'b1);
    chk("wgt_o", {NCH{COS_Q0, WGT_ZERO}}, wgt_o);
    burst(16, 300);
    load(MODE_16X, 32'h0ECA_8642, 1'b0);
    burst(12, 300);
  endtask

  // Weighted modes: every angle code appears on some channel.
  task automatic t_weighted(input cwl_mode_t m, input int mult);
    logic [127:0] e;
    for (int h = 0; h < 2; h++)
    begin
      load(m, h ? 32'hFEDC_BA98 : 32'h7654_3210, 1'b1);
      for (int c = 0; c < NCH; c++)
        e[c*16 +: 16] = {cosw(4'(h*8 + c)), cosw(4'(h*8 + c - 4))};
      chk("wgt_o", e, wgt_o);
      burst(mult, 200);
    end
  endtask

  // Clock enable low must hold the oscillator, weight and mode outputs while the clocks run and a load is pulsed.
  task automatic t_freeze;
    logic [127:0] l;
    logic [127:0] w;
    @(posedge sys_clk);
    src_mult <= 1;
    src_run <= 1'b1;
    repeat (9) @(posedge sys_clk);
    ce <= 1'b0;
    @(negedge sys_clk);
    l = lo_o;
    w = wgt_o;
    @(posedge sys_clk);
    mode_i <= MODE_8X;
    cfg_load <= 1'b1;
    @(posedge sys_clk);
    cfg_load <= 1'b0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("frozen lo_o", l, lo_o);
    chk("frozen wgt_o", w, wgt_o);
    chk("frozen mode_o", MODE_1X, mode_o);
    @(posedge sys_clk);
    ce <= 1'b1;
    src_run <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("mode_o after freeze", MODE_1X, mode_o);
  endtask

  task automatic close_out;
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      close_out();
    end
  end

  initial
  begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    t_defaults();
    t_sixteen();
    t_weighted(MODE_8X, 8);
    t_weighted(MODE_4X, 4);
    t_weighted(MODE_1X, 1);
    t_freeze();
    close_out();
  end
endmodule // testbench
